// *** verilog/cms_select_sense.sv ***
// Core memory drive/sink selection and sense/inhibit control
//
// How it works
// - X and Y read sinks conduct only while read_sink_time_n is low.
// - Y write sinks conduct only while write_sink_time_n is low.
// - Address splits into four 3-bit one-of-eight fields: XD, YD, XS, YS.
// - Driver plus X sink picks an X line; driver plus Y sink a Y line.
// - A switch conducts only with group timing and its own select low.
// - Positive drive feeds Y on read, X on write; one group per half.
// - Negative drive feeds X on read, Y on write; one group per half.
// - Upper half negative timing needs select, drive time low, half high.
// - Sense/inhibit timing needs this stack and this half selected.
// - Low byte strobe samples bits 0-7, high byte strobe bits 8-15.
// - Inhibit timing comes from write sink timing, split per byte.
// - Sense results pass only under strobe, as open-collector outputs.
// - A sensed one marks the data bit and suppresses its inhibit.
// - A sensed zero fires the inhibit driver during restore.
// - Clear/write mode suppresses the sense strobes.
// - Clear/write inhibits bits whose data register holds zero.
`timescale 1ns/1ns
`default_nettype none
module cms_select_sense
  import cms_pkg::*;
#(
  parameter logic STACK_HALF = CMS_HALF_LOWER
)(
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire cms_in_t               pins,
  output var  cms_sw_t               sw,
  output var  logic [5:0]            x_line,
  output var  logic [5:0]            y_line,
  output var  logic                  sense_strobe_low_byte,
  output var  logic                  sense_strobe_high_byte,
  output var  logic                  inhibit_pulse_low_byte,
  output var  logic                  inhibit_pulse_high_byte,
  output var  logic [CMS_DATA_W-1:0] inhibit_drive,
  output var  logic [CMS_DATA_W-1:0] data_line_out,
  output var  logic [CMS_DATA_W-1:0] data_line_oe
);

  cms_state_t           st_reg;
  cms_state_t           st_next;
  cms_in_t              s;
  logic                 stack_on;
  logic                 rd_time;
  logic                 wr_ok;
  logic                 read_ph;
  logic                 half_on;
  logic                 start;
  logic [CMS_SEL_N-1:0] xdrv_n;
  logic [CMS_SEL_N-1:0] ydrv_n;
  logic [CMS_SEL_N-1:0] xsnk_n;
  logic [CMS_SEL_N-1:0] ysnk_n;
  logic [CMS_SEL_N-1:0] pos_sel_n;
  logic [CMS_SEL_N-1:0] neg_sel_n;
  logic [CMS_DATA_W-1:0] ones;

  // Switch enables for a group: timing present and select low
  function automatic logic [CMS_SEL_N-1:0] gate8(
    input logic                 en,
    input logic [CMS_SEL_N-1:0] sel_n
  );
    gate8 = en ? ~sel_n : 8'h00;
  endfunction

  // Field decoders
  cms_decode8 u_xdrv (.code(s.addr[CMS_XDRV_LSB +: CMS_FIELD_W]),
                      .sel_n(xdrv_n));
  cms_decode8 u_ydrv (.code(s.addr[CMS_YDRV_LSB +: CMS_FIELD_W]),
                      .sel_n(ydrv_n));
  cms_decode8 u_xsnk (.code(s.addr[CMS_XSNK_LSB +: CMS_FIELD_W]),
                      .sel_n(xsnk_n));
  cms_decode8 u_ysnk (.code(s.addr[CMS_YSNK_LSB +: CMS_FIELD_W]),
                      .sel_n(ysnk_n));

  // Qualifiers from the synchronised pins
  assign s        = st_reg.sync2;
  assign stack_on = !s.stack_select_n;
  assign rd_time  = stack_on && !s.read_sink_time_n;
  assign wr_ok    = (st_reg.phase == CMS_WRITE) && !rd_time;
  assign read_ph  = (st_reg.phase != CMS_WRITE);
  assign start    = rd_time && (st_reg.phase != CMS_READ);
  assign half_on  = stack_on && (STACK_HALF ? !s.inhibit_upper_half_enable_n
                                 : !s.inhibit_lower_half_enable_n);
  // Drive multiplexing: positive feeds Y on read, negative feeds X
  assign pos_sel_n = read_ph ? ydrv_n : xdrv_n;
  assign neg_sel_n = read_ph ? xdrv_n : ydrv_n;

  // Next state
  always_comb begin
    st_next       = st_reg;
    st_next.sync1 = pins;
    st_next.sync2 = st_reg.sync1;
    // Memory cycle phase tracking
    unique case (st_reg.phase)
      CMS_IDLE: begin
        if (rd_time) st_next.phase = CMS_READ;
      end
      CMS_READ: begin
        if (!rd_time) st_next.phase = CMS_WRITE;
      end
      CMS_WRITE: begin
        if (rd_time) st_next.phase = CMS_READ;
        else if (!stack_on) st_next.phase = CMS_IDLE;
      end
      // Unused code falls back to idle
      default: st_next.phase = CMS_IDLE;
    endcase
    // Driver groups per half
    st_next.sw.pos_lo = gate8(stack_on && !s.pos_drive_time_n &&
                              !s.stack_half_select, pos_sel_n);
    st_next.sw.pos_hi = gate8(stack_on && !s.pos_drive_time_n &&
                              s.stack_half_select, pos_sel_n);
    st_next.sw.neg_lo = gate8(stack_on && !s.neg_drive_time_n &&
                              !s.stack_half_select, neg_sel_n);
    st_next.sw.neg_hi = gate8(stack_on && !s.neg_drive_time_n &&
                              s.stack_half_select, neg_sel_n);
    // Sink groups shared by both halves
    st_next.sw.x_rd_sink = gate8(rd_time, xsnk_n);
    st_next.sw.y_rd_sink = gate8(rd_time, ysnk_n);
    st_next.sw.x_wr_sink = gate8(wr_ok && stack_on &&
                                 !s.write_sink_timing_n, xsnk_n);
    st_next.sw.y_wr_sink = gate8(wr_ok && stack_on &&
                                 !s.write_sink_time_n, ysnk_n);
    // Selected line indices
    st_next.x_line = {s.addr[CMS_XSNK_LSB +: CMS_FIELD_W],
                      s.addr[CMS_XDRV_LSB +: CMS_FIELD_W]};
    st_next.y_line = {s.addr[CMS_YSNK_LSB +: CMS_FIELD_W],
                      s.addr[CMS_YDRV_LSB +: CMS_FIELD_W]};
    // Byte sense strobes, withheld in clear/write mode
    st_next.sas_lo = half_on && !s.sense_strobe_n &&
                     !s.clear_write_mode;
    st_next.sas_hi = st_next.sas_lo;
    // Sensed ones; a new strobe hit wins over the cycle-start clear
    st_next.sensed = (start ? 16'h0000 : st_reg.sensed) |
                     ({{CMS_BYTE_W{st_next.sas_hi}},
                       {CMS_BYTE_W{st_next.sas_lo}}} & s.sense_line);
    // Open-collector pull-down while strobed
    st_next.data_oe = {{CMS_BYTE_W{st_next.sas_hi}},
                       {CMS_BYTE_W{st_next.sas_lo}}} & s.sense_line;
    // Inhibit timing from write sink timing, per byte
    st_next.inh_lo = half_on && wr_ok && !s.write_sink_timing_n;
    st_next.inh_hi = st_next.inh_lo;
    // Bits that must end as one
    ones = s.clear_write_mode ? ~s.write_data_n : st_next.sensed;
    // Inhibit only bits that must stay zero
    st_next.inh_drv = {{CMS_BYTE_W{st_next.inh_hi}},
                       {CMS_BYTE_W{st_next.inh_lo}}} & ~ones;
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= CMS_STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register; data_line_out is tied low
  assign sw                      = st_reg.sw;
  assign x_line                  = st_reg.x_line;
  assign y_line                  = st_reg.y_line;
  assign sense_strobe_low_byte   = st_reg.sas_lo;
  assign sense_strobe_high_byte  = st_reg.sas_hi;
  assign inhibit_pulse_low_byte  = st_reg.inh_lo;
  assign inhibit_pulse_high_byte = st_reg.inh_hi;
  assign inhibit_drive           = st_reg.inh_drv;
  assign data_line_out           = 16'h0000;
  assign data_line_oe            = st_reg.data_oe;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  rd_sink_gate_a: assert property (
    (|sw.x_rd_sink || |sw.y_rd_sink) |-> $past(rd_time))
    else $error("read sink on without read sink time");
  wr_sink_gate_a: assert property (
    |sw.y_wr_sink |-> !$past(s.write_sink_time_n) && $past(stack_on))
    else $error("Y write sink on without write sink time");
  addr_field_a: assert property (
    |sw.x_rd_sink |->
      sw.x_rd_sink == (8'h01 << $past(s.addr[CMS_XSNK_LSB +: 3])))
    else $error("X sink does not match address field");
  line_index_a: assert property (
    |sw.y_rd_sink |-> sw.y_rd_sink == (8'h01 << y_line[5:3]))
    else $error("Y line index disagrees with Y sink");
  one_switch_a: assert property (
    $onehot0(sw.pos_lo) && $onehot0(sw.neg_lo) &&
    $onehot0(sw.pos_hi) && $onehot0(sw.neg_hi) && $onehot0(sw.x_wr_sink))
    else $error("more than one switch of a group on");
  pos_read_y_a: assert property (
    (|sw.pos_lo && $past(read_ph)) |->
      sw.pos_lo == (8'h01 << y_line[2:0]) && !(|sw.pos_hi))
    else $error("positive drive not on Y line in read");
  neg_half_a: assert property (
    |sw.neg_hi |-> $past(s.stack_half_select) &&
      !$past(s.neg_drive_time_n) && !$past(s.stack_select_n))
    else $error("upper negative drive without its timing");
  half_gate_a: assert property (
    (sense_strobe_low_byte || inhibit_pulse_low_byte) |-> $past(half_on))
    else $error("sense/inhibit timing without half select");
  strobe_split_a: assert property (
    (|data_line_oe[7:0] |-> sense_strobe_low_byte) and
    (|data_line_oe[15:8] |-> sense_strobe_high_byte))
    else $error("data line driven outside its byte strobe");
  inh_split_a: assert property (
    (|inhibit_drive[15:8] |-> inhibit_pulse_high_byte) and
    (inhibit_pulse_low_byte |-> !$past(s.write_sink_timing_n)))
    else $error("inhibit driver outside inhibit timing");
  one_no_inh_a: assert property (
    !$past(s.clear_write_mode) |-> (inhibit_drive & st_reg.sensed) == 0)
    else $error("inhibit fired on a sensed one");
  zero_inh_a: assert property (
    (inhibit_pulse_low_byte && !$past(s.clear_write_mode)) |->
      inhibit_drive[7:0] == ~st_reg.sensed[7:0])
    else $error("sensed zero not inhibited on restore");
  clear_strobe_a: assert property (
    $past(s.clear_write_mode) |->
      !sense_strobe_low_byte && !sense_strobe_high_byte)
    else $error("sense strobe in clear/write mode");
  cw_data_a: assert property (
    (inhibit_pulse_high_byte && $past(s.clear_write_mode)) |->
      inhibit_drive[15:8] == $past(s.write_data_n[15:8]))
    else $error("clear/write inhibit disagrees with data");
  rw_excl_a: assert property (
    (|sw.x_wr_sink || |sw.y_wr_sink) |->
      !(|sw.x_rd_sink) && $past(st_reg.phase) == CMS_WRITE)
    else $error("write sink overlaps read or skipped read");

  read_cycle_c: cover property (|sw.x_rd_sink ##[1:20] |sw.y_wr_sink);
  sense_one_c: cover property (sense_strobe_low_byte && |data_line_oe);
  restore_c: cover property (inhibit_pulse_low_byte && |inhibit_drive);
  clear_write_c: cover property (
    $past(s.clear_write_mode) && inhibit_pulse_high_byte);
endmodule
`default_nettype wire

// *** include/cms_pkg.sv ***
// Shared constants and carrier types for the core memory select/sense block
package cms_pkg;
  localparam int CMS_ADDR_W  = 12;
  localparam int CMS_DATA_W  = 16;
  localparam int CMS_BYTE_W  = 8;
  localparam int CMS_FIELD_W = 3;
  localparam int CMS_SEL_N   = 8;
  // Address field positions
  localparam int CMS_XDRV_LSB = 0;
  localparam int CMS_YDRV_LSB = 3;
  localparam int CMS_XSNK_LSB = 6;
  localparam int CMS_YSNK_LSB = 9;
  // Stack half codes
  localparam logic CMS_HALF_LOWER = 1'b0;
  localparam logic CMS_HALF_UPPER = 1'b1;

  typedef enum logic [1:0] {
    CMS_IDLE  = 2'b00,
    CMS_READ  = 2'b01,
    CMS_WRITE = 2'b11
  } cms_phase_t;

  // Pins arriving from timing control, data register and sense amplifiers
  typedef struct packed {
    logic [CMS_ADDR_W-1:0] addr;
    logic                  stack_half_select;
    logic                  stack_select_n;
    logic                  read_sink_time_n;
    logic                  write_sink_time_n;
    logic                  write_sink_timing_n;
    logic                  pos_drive_time_n;
    logic                  neg_drive_time_n;
    logic                  inhibit_lower_half_enable_n;
    logic                  inhibit_upper_half_enable_n;
    logic                  sense_strobe_n;
    logic                  clear_write_mode;
    logic [CMS_DATA_W-1:0] write_data_n;
    logic [CMS_DATA_W-1:0] sense_line;
  } cms_in_t;

  // Switch enables toward the stack, one bit per switch
  typedef struct packed {
    logic [CMS_SEL_N-1:0] pos_lo;
    logic [CMS_SEL_N-1:0] pos_hi;
    logic [CMS_SEL_N-1:0] neg_lo;
    logic [CMS_SEL_N-1:0] neg_hi;
    logic [CMS_SEL_N-1:0] x_rd_sink;
    logic [CMS_SEL_N-1:0] y_rd_sink;
    logic [CMS_SEL_N-1:0] x_wr_sink;
    logic [CMS_SEL_N-1:0] y_wr_sink;
  } cms_sw_t;

  typedef struct packed {
    cms_in_t               sync1;
    cms_in_t               sync2;
    cms_phase_t            phase;
    cms_sw_t               sw;
    logic [5:0]            x_line;
    logic [5:0]            y_line;
    logic                  sas_lo;
    logic                  sas_hi;
    logic                  inh_lo;
    logic                  inh_hi;
    logic [CMS_DATA_W-1:0] sensed;
    logic [CMS_DATA_W-1:0] inh_drv;
    logic [CMS_DATA_W-1:0] data_oe;
  } cms_state_t;

  // Idle pin levels: every active-low strobe high
  localparam cms_in_t CMS_IN_RESET = '{
    addr: 12'h000, stack_half_select: 1'b0, stack_select_n: 1'b1,
    read_sink_time_n: 1'b1, write_sink_time_n: 1'b1,
    write_sink_timing_n: 1'b1, pos_drive_time_n: 1'b1,
    neg_drive_time_n: 1'b1, inhibit_lower_half_enable_n: 1'b1,
    inhibit_upper_half_enable_n: 1'b1, sense_strobe_n: 1'b1,
    clear_write_mode: 1'b0, write_data_n: 16'hFFFF, sense_line: 16'h0000};

  localparam cms_state_t CMS_STATE_RESET = '{
    sync1: CMS_IN_RESET, sync2: CMS_IN_RESET, phase: CMS_IDLE,
    sw: '0, x_line: 6'h00, y_line: 6'h00, sas_lo: 1'b0, sas_hi: 1'b0,
    inh_lo: 1'b0, inh_hi: 1'b0, sensed: 16'h0000, inh_drv: 16'h0000,
    data_oe: 16'h0000};
endpackage

// *** verilog/cms_decode8.sv ***
// One-of-eight active-low decoder for a 3-bit address field
`timescale 1ns/1ns
`default_nettype none
module cms_decode8
  import cms_pkg::*;
(
  input  wire logic [CMS_FIELD_W-1:0] code,
  output var  logic [CMS_SEL_N-1:0]   sel_n
);
  // Exactly one output low for any code
  always_comb begin
    sel_n       = 8'hFF;
    sel_n[code] = 1'b0;
  end
endmodule
`default_nettype wire

// *** test/cms_stack_model.sv ***
// Behavioural core stack: stores words, answers sense, takes inhibits
`timescale 1ns/1ns
`default_nettype none
module cms_stack_model
  import cms_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire cms_sw_t               sw,
  input  wire logic [5:0]            x_line,
  input  wire logic [5:0]            y_line,
  input  wire logic                  inh_lo,
  input  wire logic                  inh_hi,
  input  wire logic [CMS_DATA_W-1:0] inhibit_drive,
  output var  logic [CMS_DATA_W-1:0] sense_line
);
  logic [CMS_DATA_W-1:0] mem [0:4095];
  logic [4095:0]         written_reg = '0;
  logic [CMS_DATA_W-1:0] noise_reg = 16'h3C96;
  logic [11:0]           key;

  assign key = {y_line, x_line};
  // Cores switch to one except where inhibit current flows
  always @(posedge sys_clk) begin
    noise_reg <= ~noise_reg;
    if (|sw.x_wr_sink && |sw.y_wr_sink && inh_lo && inh_hi) begin
      mem[key]         <= ~inhibit_drive;
      written_reg[key] <= 1'b1;
    end
  end
  // Unselected sense lines toggle so a stray sample cannot pass as data
  always_comb begin
    if (|sw.x_rd_sink && |sw.y_rd_sink)
      sense_line = written_reg[key] ? mem[key] : 16'hA55A;
    else
      sense_line = noise_reg;
  end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the select/sense block with a core stack model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cms_pkg::*;
  typedef struct packed {
    cms_sw_t     sw;
    logic [7:0]  fl;
    logic [15:0] dl;
    logic [15:0] inh;
    logic [15:0] ln;
  } cms_note_t;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  cms_in_t     pins = CMS_IN_RESET;
  cms_in_t     pins_w;
  cms_sw_t     sw;
  logic [5:0]  x_line, y_line;
  logic        sas_lo, sas_hi, inh_lo, inh_hi;
  logic        sas_lo_u, sas_hi_u, inh_lo_u, inh_hi_u;
  logic [3:0]  fl_lo, fl_hi;
  logic [15:0] inhibit_drive, dl_out, dl_oe, data_line, sense_w;
  cms_note_t   notes[$];
  cms_note_t   n;
  event        chk_ev;
  int          failures = 0;
  int          cmp_count = 0;
  int          seed;
  logic [11:0] a;
  logic [15:0] d;
  logic        h;

  initial forever #10 sys_clk = ~sys_clk;
  // Sense amplifiers come from the stack model; wired-OR pulls low
  always_comb begin
    pins_w = pins;
    pins_w.sense_line = sense_w;
  end
  assign data_line = (dl_oe & dl_out) | ~dl_oe;
  assign fl_lo = {sas_lo, sas_hi, inh_lo, inh_hi};
  assign fl_hi = {sas_lo_u, sas_hi_u, inh_lo_u, inh_hi_u};

  cms_select_sense dut (.sys_clk(sys_clk), .resetn(resetn), .pins(pins_w),
    .sw(sw), .x_line(x_line), .y_line(y_line),
    .sense_strobe_low_byte(sas_lo), .sense_strobe_high_byte(sas_hi),
    .inhibit_pulse_low_byte(inh_lo), .inhibit_pulse_high_byte(inh_hi),
    .inhibit_drive(inhibit_drive), .data_line_out(dl_out),
    .data_line_oe(dl_oe));
  // Upper-half card: answers only to the upper half enable
  cms_select_sense #(.STACK_HALF(CMS_HALF_UPPER)) dut_hi (
    .sys_clk(sys_clk), .resetn(resetn), .pins(pins_w),
    .sw(), .x_line(), .y_line(),
    .sense_strobe_low_byte(sas_lo_u), .sense_strobe_high_byte(sas_hi_u),
    .inhibit_pulse_low_byte(inh_lo_u), .inhibit_pulse_high_byte(inh_hi_u),
    .inhibit_drive(), .data_line_out(), .data_line_oe());
  cms_stack_model stack (.sys_clk(sys_clk), .sw(sw), .x_line(x_line),
    .y_line(y_line), .inh_lo(inh_lo), .inh_hi(inh_hi),
    .inhibit_drive(inhibit_drive), .sense_line(sense_w));

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp_sw(input cms_sw_t g, input cms_sw_t e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] oh(input logic [2:0] c);
    return 8'h01 << c;
  endfunction
  // Phase 0 off, 1 read, 2 write drivers, 3 write drivers and sinks
  function automatic cms_sw_t mk_sw(input logic [11:0] ad, input logic hf,
                                    input logic [1:0] ph);
    cms_sw_t     s;
    logic [7:0]  p, q;
    s = '0;
    p = (ph == 2'd1) ? oh(ad[5:3]) : oh(ad[2:0]);
    q = (ph == 2'd1) ? oh(ad[2:0]) : oh(ad[5:3]);
    if (ph != 2'd0 && hf) s.pos_hi = p;
    if (ph != 2'd0 && hf) s.neg_hi = q;
    if (ph != 2'd0 && !hf) s.pos_lo = p;
    if (ph != 2'd0 && !hf) s.neg_lo = q;
    if (ph == 2'd1) s.x_rd_sink = oh(ad[8:6]);
    if (ph == 2'd1) s.y_rd_sink = oh(ad[11:9]);
    if (ph == 2'd3) s.x_wr_sink = oh(ad[8:6]);
    if (ph == 2'd3) s.y_wr_sink = oh(ad[11:9]);
    return s;
  endfunction
  // Note the expected outputs, then let the watcher compare them
  task automatic note_chk(input cms_sw_t s, input logic [7:0] fl,
                          input logic [15:0] dl, input logic [15:0] inh);
    notes.push_back({s, fl, dl, inh,
                     {4'h0, pins.addr[8:6], pins.addr[2:0],
                      pins.addr[11:9], pins.addr[5:3]}});
    ->chk_ev;
  endtask
  task automatic run_step(input cms_sw_t s, input logic [7:0] fl,
                          input logic [15:0] dl, input logic [15:0] inh);
    repeat (6) @(negedge sys_clk);
    note_chk(s, fl, dl, inh);
  endtask
  // One memory cycle: read, strobe, read end, write, idle
  task automatic mem_op(input logic [11:0] ad, input logic hf,
                        input logic cw, input logic up, input logic [15:0] w);
    logic ok;
    ok = !up;
    pins.addr = ad;
    pins.stack_half_select = hf;
    pins.stack_select_n = 1'b0;
    pins.read_sink_time_n = 1'b0;
    pins.pos_drive_time_n = 1'b0;
    pins.neg_drive_time_n = 1'b0;
    pins.inhibit_lower_half_enable_n = up;
    pins.inhibit_upper_half_enable_n = !up;
    pins.clear_write_mode = cw;
    pins.write_data_n = ~w;
    run_step(mk_sw(ad, hf, 2'd1), 8'h00, 16'hFFFF, 16'h0000);
    pins.sense_strobe_n = 1'b0;
    // Flags: lower-half card in the high nibble, upper-half card below
    run_step(mk_sw(ad, hf, 2'd1),
             {((ok && !cw) ? 4'hC : 4'h0), ((up && !cw) ? 4'hC : 4'h0)},
             (ok && !cw) ? ~w : 16'hFFFF, 16'h0000);
    pins.sense_strobe_n = 1'b1;
    run_step(mk_sw(ad, hf, 2'd1), 8'h00, 16'hFFFF, 16'h0000);
    pins.read_sink_time_n = 1'b1;
    run_step(mk_sw(ad, hf, 2'd2), 8'h00, 16'hFFFF, 16'h0000);
    pins.write_sink_time_n = 1'b0;
    pins.write_sink_timing_n = 1'b0;
    run_step(mk_sw(ad, hf, 2'd3), {(ok ? 4'h3 : 4'h0), (up ? 4'h3 : 4'h0)},
             16'hFFFF, ok ? ~w : 16'h0000);
    pins = CMS_IN_RESET;
    pins.addr = ad;
    run_step('0, 8'h00, 16'hFFFF, 16'h0000);
  endtask

  // Watcher: compares the oldest note with the settled outputs
  always begin
    @(chk_ev);
    n = notes.pop_front();
    cmp_sw(sw, n.sw);
    cmp16({12'h000, fl_lo}, {12'h000, n.fl[7:4]});
    cmp16({12'h000, fl_hi}, {12'h000, n.fl[3:0]});
    cmp16(data_line, n.dl);
    cmp16(inhibit_drive, n.inh);
    cmp16({4'h0, x_line, y_line}, n.ln);
  end
  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    stop_test();
  end
  // Main sequence: reset, then clear/write, restore, other half, restore
  initial begin
    seed = 57;
    repeat (4) @(negedge sys_clk);
    note_chk('0, 8'h00, 16'hFFFF, 16'h0000);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($random(seed));
      d = 16'($random(seed));
      h = 1'($random(seed));
      mem_op(a, h, 1'b1, 1'b0, d);
      mem_op(a, ~h, 1'b0, 1'b0, d);
      mem_op(a, h, 1'b0, 1'b1, d);
      mem_op(a, h, 1'b0, 1'b0, d);
    end
    @(negedge sys_clk);
    if (notes.size() != 0)
      failures++;
    stop_test();
  end
endmodule
`default_nettype wire
